// ===== inc/osmc_map.vh
`ifndef OSMC_MAP_VH
`define OSMC_MAP_VH
// Register offsets.
`define OSMC_OFF_LIGHT_CTRL  8'h15
`define OSMC_OFF_PROX_CTRL   8'h16
`define OSMC_OFF_CURR_LO     8'h17
`define OSMC_OFF_CURR_HI     8'h18
`define OSMC_OFF_CAN_PULSE   8'h19
`define OSMC_OFF_PW_PERIOD   8'h1A
`define OSMC_OFF_DIG_LO      8'h1B
`define OSMC_OFF_DIG_HI      8'h1C
// Reset values.
`define OSMC_RST_LIGHT_CTRL  8'h00
`define OSMC_RST_PROX_CTRL   8'h00
`define OSMC_RST_CURR_LO     8'hFF
`define OSMC_RST_CURR_HI     8'h01
`define OSMC_RST_CAN_PULSE   8'h1A
`define OSMC_RST_PW_PERIOD   8'h15
`define OSMC_RST_DIG_LO      8'h00
`define OSMC_RST_DIG_HI      8'h00
// Field positions.
`define OSMC_BIT_SWRST       7
`define OSMC_BIT_SAI         3
`define OSMC_BIT_CHSEL       1
`define OSMC_BIT_EN          0
`define OSMC_BIT_ANA         6
`define OSMC_POS_MODE_LO     1
`define OSMC_POS_PCNT_LO     3
`define OSMC_POS_PW_LO       4
`define OSMC_POS_PER_LO      0
// Measurement mode codes.
`define OSMC_MODE_PROX       2'h0
`define OSMC_MODE_SINGLE     2'h1
`define OSMC_MODE_DUAL       2'h2
// Timing: 200 MHz core clock.
`define OSMC_CLK_MHZ         200
// Pulse widths in microseconds, sized for the duration output.
`define OSMC_T26_US          7'h1A
`define OSMC_T42_US          7'h2A
`define OSMC_T71_US          7'h47
`define OSMC_BASE_PERIOD_US  3125
`define OSMC_SWRST_MS        10
`endif

// ===== logic/osmc_sync.v
`default_nettype none
module osmc_sync (
  // Clock and reset.
  input  wire core_clk_i,
  input  wire sys_rst_i,
  // Asynchronous level in, synchronised level out.
  input  wire async_i,
  output wire sync_o
);
  reg meta_ff;
  reg sync_ff;

  // Two flip-flop synchroniser; only the second stage is read.
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// ===== logic/osmc_res.v
`default_nettype none
module osmc_res (
  // Pulse settings.
  input  wire [1:0] pw_code_i,
  input  wire [2:0] pcnt_code_i,
  input  wire [2:0] per_code_i,
  // Derived values.
  output reg  [5:0] pulses_o,
  output reg  [4:0] res_bits_o
);
  reg [2:0] lg;
  reg [2:0] cap_lg;
  reg [4:0] base;
  reg [5:0] r;

  // Effective pulse count with period cap, and resulting resolution.
  always @* begin
    lg = (pcnt_code_i > 3'h5) ? 3'h5 : pcnt_code_i;
    cap_lg = 3'h5;
    if (pw_code_i == 2'h1 && per_code_i == 3'h0)
      cap_lg = 3'h4;
    // The reserved width code runs as the widest pulse, so it is capped too.
    if (pw_code_i[1] && per_code_i == 3'h0)
      cap_lg = 3'h3;
    if (pw_code_i[1] && per_code_i == 3'h1)
      cap_lg = 3'h4;
    if (lg > cap_lg)
      lg = cap_lg;
    pulses_o = 6'h01 << lg;
    case (pw_code_i)
      2'h0:    base = 5'd10;
      2'h1:    base = 5'd12;
      default: base = 5'd14;
    endcase
    r = {1'b0, base} + {3'h0, lg};
    res_bits_o = (r > 6'd16) ? 5'd16 : r[4:0];
  end
endmodule
`default_nettype wire

// ===== logic/osmc_ctrl.v
`include "osmc_map.vh"
`default_nettype none
// Behaviour
// - Light sleep-after-irq: enable cleared after done and status read; bit 0 stays set and light_enable_o drops until the next status read.
// - Channel select, checked only when enabled: 0 green/clear/comp, 1 all.
// - Light enable is bit 0 of light control, reset inactive.
// - Prox sleep-after-irq clears engine enable after measure done and read.
// - Mode 00 proximity, 01 single LED (IR, red if swapped), 11 reserved.
// - Mode 10 alternates IR and red, IR first, red first if swapped.
// - Bit 0 of prox control enables engine, reset inactive.
// - Emitter current is 10-bit code, reset 1FF, linear to 3FF.
// - Analog offset cancel bit removes half full scale, reset off.
// - Pulse count codes give 1..16 pulses, 101..111 give 32, reset 8.
// - Pulse count capped when pulses do not fit the period.
// - Pulse width codes 26, 42, 71 us, 11 reserved, reset 42.
// - Period codes select 3.125 to 400 ms, reset 100 ms.
// - Result resolution follows pulse width and count, saturating at 16.
// - Digital cancel value subtracted from each raw proximity result.
// - Software reset: no acknowledge, operational after 10 ms, no POR flag.
// - With light sleep cleared, light sensing continues after interrupt.
module osmc_ctrl #(
  parameter SWRST_CYCLES = `OSMC_SWRST_MS * 1000 * `OSMC_CLK_MHZ
) (
  // Clock and reset.
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  // Byte register port from the serial slave.
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  output wire        reg_ack_o,
  // Status register reads and interrupt flags from the status block.
  input  wire        status0_rd_i,
  input  wire        status1_rd_i,
  input  wire        light_irq_i,
  input  wire        prox_irq_i,
  // Measurement done strobes from the engines.
  input  wire        light_done_i,
  input  wire        prox_done_i,
  // Raw proximity result from the front end, asynchronous.
  input  wire        raw_valid_i,
  input  wire [15:0] raw_result_i,
  // Light engine controls.
  output wire        light_enable_o,
  output wire        light_all_channels_o,
  // Optical engine controls.
  output wire        optical_meas_enable_o,
  output wire [1:0]  optical_meas_mode_o,
  output wire        led_sel_red_o,
  output wire [9:0]  emitter_current_o,
  output wire        analog_offset_cancel_o,
  output wire [5:0]  pulse_count_o,
  output wire [6:0]  emitter_pulse_duration_o,
  output wire [2:0]  prox_interval_o,
  output wire [4:0]  prox_res_bits_o,
  // Cancelled proximity result.
  output reg  [15:0] prox_result_o,
  output reg         prox_result_valid_o,
  // Software reset in progress.
  output wire        sw_reset_busy_o
);
  localparam [23:0] SWRST_CNT = SWRST_CYCLES;
  // One-hot states: normal running, and waiting out a software reset.
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_SWR = 2'b10;

  // Control registers.
  reg [7:0]  light_ctrl_ff;
  reg [7:0]  prox_ctrl_ff;
  reg [7:0]  curr_lo_ff;
  reg [7:0]  curr_hi_ff;
  reg [7:0]  can_pulse_ff;
  reg [7:0]  pw_period_ff;
  reg [7:0]  dig_lo_ff;
  reg [7:0]  dig_hi_ff;
  // Sleep-after-interrupt tracking.
  reg        light_pend_ff;
  reg        light_slept_ff;
  reg        prox_pend_ff;
  // Active configuration copy, refreshed at each measurement end.
  reg [7:0]  act_curr_lo_ff;
  reg [7:0]  act_curr_hi_ff;
  reg [7:0]  act_can_pulse_ff;
  reg [7:0]  act_pw_period_ff;
  reg [1:0]  act_mode_ff;
  reg        act_swap_ff;
  reg        act_en_ff;
  // Alternation and reset state.
  reg        dual_phase_ff;
  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [23:0] swr_cnt_ff;
  reg [23:0] nxt_swr_cnt;
  // Synchronised raw input.
  wire       raw_valid_s;
  reg        raw_valid_d_ff;
  reg [15:0] raw_meta_ff;
  reg [15:0] raw_hold_ff;
  wire [5:0] pulses;
  wire [4:0] res_bits;
  wire       swr_req;
  wire       prox_started;

  // Decodes one register offset into a select.
  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // Maps the pulse width code onto microseconds.
  function [6:0] pw_us;
    input [1:0] c;
    begin
      case (c)
        2'h0:    pw_us = `OSMC_T26_US;
        2'h1:    pw_us = `OSMC_T42_US;
        default: pw_us = `OSMC_T71_US;
      endcase
    end
  endfunction

  assign swr_req = reg_wr_i && sel(reg_addr_i, `OSMC_OFF_LIGHT_CTRL) &&
                   reg_wdata_i[`OSMC_BIT_SWRST];
  // Software reset write is not acknowledged, since the part restarts at
  // once; nothing is acknowledged until the wait has run out.
  assign reg_ack_o = (reg_wr_i || reg_rd_i) && state_ff == ST_RUN &&
                     !swr_req;
  assign sw_reset_busy_o = (state_ff == ST_SWR);
  assign prox_started = prox_ctrl_ff[`OSMC_BIT_EN];

  // Software reset state machine.
  // The counter stands for the restart delay of the part.
  always @* begin
    nxt_state = state_ff;
    nxt_swr_cnt = swr_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (swr_req) begin
          nxt_state = ST_SWR;
          nxt_swr_cnt = SWRST_CNT;
        end
      end
      ST_SWR: begin
        if (swr_cnt_ff <= 24'h000001)
          nxt_state = ST_RUN;
        else
          nxt_swr_cnt = swr_cnt_ff - 24'h000001;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_RUN;
      swr_cnt_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      swr_cnt_ff <= nxt_swr_cnt;
    end
  end

  // Register writes; software reset restores all defaults.
  // Writes are only taken in the running state.
  always @(posedge core_clk_i) begin
    if (sys_rst_i || swr_req) begin
      light_ctrl_ff <= `OSMC_RST_LIGHT_CTRL;
      prox_ctrl_ff <= `OSMC_RST_PROX_CTRL;
      curr_lo_ff <= `OSMC_RST_CURR_LO;
      curr_hi_ff <= `OSMC_RST_CURR_HI;
      can_pulse_ff <= `OSMC_RST_CAN_PULSE;
      pw_period_ff <= `OSMC_RST_PW_PERIOD;
      dig_lo_ff <= `OSMC_RST_DIG_LO;
      dig_hi_ff <= `OSMC_RST_DIG_HI;
      light_pend_ff <= 1'b0;
      light_slept_ff <= 1'b0;
      prox_pend_ff <= 1'b0;
    end else if (state_ff == ST_RUN) begin
      if (reg_wr_i) begin
        // Written bytes are stored whole, fixed bits included.
        if (sel(reg_addr_i, `OSMC_OFF_LIGHT_CTRL))
          light_ctrl_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_PROX_CTRL))
          prox_ctrl_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_CURR_LO))
          curr_lo_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_CURR_HI))
          curr_hi_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_CAN_PULSE))
          can_pulse_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_PW_PERIOD))
          pw_period_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_DIG_LO))
          dig_lo_ff <= reg_wdata_i;
        if (sel(reg_addr_i, `OSMC_OFF_DIG_HI))
          dig_hi_ff <= reg_wdata_i;
      end
      // Light: sleep on done with a status read, wake on the next read.
      // Arming comes last so that an interrupt in the same cycle as the
      // sleep keeps the engine armed.
      if (light_pend_ff && light_done_i && status0_rd_i) begin
        light_pend_ff <= 1'b0;
        light_slept_ff <= 1'b1;
      end else if (light_slept_ff && status0_rd_i) begin
        light_slept_ff <= 1'b0;
      end
      if (light_ctrl_ff[`OSMC_BIT_SAI] && light_irq_i)
        light_pend_ff <= 1'b1;
      else if (!light_ctrl_ff[`OSMC_BIT_SAI])
        light_pend_ff <= 1'b0;
      // Prox: the enable bit itself drops, so the host can see it.
      // Clearing the sleep bit disarms and keeps the engine running.
      if (prox_pend_ff && prox_done_i && status1_rd_i) begin
        prox_pend_ff <= 1'b0;
        prox_ctrl_ff[`OSMC_BIT_EN] <= 1'b0;
      end
      if (prox_ctrl_ff[`OSMC_BIT_SAI] && prox_irq_i)
        prox_pend_ff <= 1'b1;
      else if (!prox_ctrl_ff[`OSMC_BIT_SAI])
        prox_pend_ff <= 1'b0;
    end
  end

  // Read mux returns stored bytes; unmapped reads zero.
  // Fixed bits come back exactly as the host wrote them.
  always @* begin
    reg_rdata_o = 8'h00;
    case (reg_addr_i)
      `OSMC_OFF_LIGHT_CTRL: reg_rdata_o = light_ctrl_ff;
      `OSMC_OFF_PROX_CTRL:  reg_rdata_o = prox_ctrl_ff;
      `OSMC_OFF_CURR_LO:    reg_rdata_o = curr_lo_ff;
      `OSMC_OFF_CURR_HI:    reg_rdata_o = curr_hi_ff;
      `OSMC_OFF_CAN_PULSE:  reg_rdata_o = can_pulse_ff;
      `OSMC_OFF_PW_PERIOD:  reg_rdata_o = pw_period_ff;
      `OSMC_OFF_DIG_LO:     reg_rdata_o = dig_lo_ff;
      `OSMC_OFF_DIG_HI:     reg_rdata_o = dig_hi_ff;
      default:              reg_rdata_o = 8'h00;
    endcase
  end

  // Configuration moves to the engine at measurement boundaries.
  // Copying only at a done strobe keeps one measurement's settings whole;
  // while the engine is idle the copy simply follows the registers.
  always @(posedge core_clk_i) begin
    if (sys_rst_i || swr_req) begin
      act_curr_lo_ff <= `OSMC_RST_CURR_LO;
      act_curr_hi_ff <= `OSMC_RST_CURR_HI;
      act_can_pulse_ff <= `OSMC_RST_CAN_PULSE;
      act_pw_period_ff <= `OSMC_RST_PW_PERIOD;
      act_mode_ff <= `OSMC_MODE_PROX;
      act_swap_ff <= 1'b0;
      act_en_ff <= 1'b0;
      dual_phase_ff <= 1'b0;
    end else if (prox_done_i || !act_en_ff) begin
      act_curr_lo_ff <= curr_lo_ff;
      act_curr_hi_ff <= curr_hi_ff;
      act_can_pulse_ff <= can_pulse_ff;
      act_pw_period_ff <= pw_period_ff;
      act_mode_ff <= prox_ctrl_ff[`OSMC_POS_MODE_LO +: 2];
      act_swap_ff <= prox_ctrl_ff[7];
      act_en_ff <= prox_started;
      if (!act_en_ff || act_mode_ff != `OSMC_MODE_DUAL)
        dual_phase_ff <= 1'b0;
      else
        dual_phase_ff <= ~dual_phase_ff;
    end
  end

  // Light controls; channel select only matters while enabled.
  // A sleeping light engine also drops its channel request.
  assign light_enable_o = light_ctrl_ff[`OSMC_BIT_EN] &&
                          !light_slept_ff;
  assign light_all_channels_o = light_enable_o &&
                                light_ctrl_ff[`OSMC_BIT_CHSEL];

  // Optical engine controls from the active copy.
  // Writes made mid-measurement wait here for the next done strobe; clearing the enable bit stops the engine at once.
  assign optical_meas_enable_o = act_en_ff && prox_started;
  assign optical_meas_mode_o = act_mode_ff;
  assign led_sel_red_o = (act_mode_ff == `OSMC_MODE_DUAL) ?
                         (dual_phase_ff ^ act_swap_ff) :
                         act_swap_ff;
  assign emitter_current_o = {act_curr_hi_ff[1:0], act_curr_lo_ff};
  assign analog_offset_cancel_o = act_can_pulse_ff[`OSMC_BIT_ANA];
  assign emitter_pulse_duration_o =
    pw_us(act_pw_period_ff[`OSMC_POS_PW_LO +: 2]);
  assign prox_interval_o = act_pw_period_ff[`OSMC_POS_PER_LO +: 3];
  assign pulse_count_o = pulses;
  assign prox_res_bits_o = res_bits;

  // Pulse count after the period cap, and the resolution it yields.
  osmc_res u_res (
    .pw_code_i   (act_pw_period_ff[`OSMC_POS_PW_LO +: 2]),
    .pcnt_code_i (act_can_pulse_ff[`OSMC_POS_PCNT_LO +: 3]),
    .per_code_i  (act_pw_period_ff[`OSMC_POS_PER_LO +: 3]),
    .pulses_o    (pulses),
    .res_bits_o  (res_bits)
  );

  // The valid level comes from the front end's own domain.
  osmc_sync u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (raw_valid_i),
    .sync_o     (raw_valid_s)
  );

  // Raw data is held stable by the front end while valid is high; it still
  // crosses domains, so it passes two stages like valid before use.
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      raw_valid_d_ff <= 1'b0;
      raw_meta_ff <= 16'h0000;
      raw_hold_ff <= 16'h0000;
      prox_result_o <= 16'h0000;
      prox_result_valid_o <= 1'b0;
    end else begin
      raw_valid_d_ff <= raw_valid_s;
      raw_meta_ff <= raw_result_i;
      raw_hold_ff <= raw_meta_ff;
      prox_result_valid_o <= raw_valid_s && !raw_valid_d_ff;
      if (raw_valid_s && !raw_valid_d_ff) begin
        // Subtract cancel level, floor at zero.
        if (raw_hold_ff > {dig_hi_ff, dig_lo_ff})
          prox_result_o <= raw_hold_ff - {dig_hi_ff, dig_lo_ff};
        else
          prox_result_o <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/osmc_fe_model.sv
`default_nettype none
module osmc_fe_model (
  // Clock and request from the bench.
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] val_i,
  // Raw result lines into the block.
  output var  logic        raw_valid_o,
  output var  logic [15:0] raw_result_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Raises valid off the core clock, holds the data, then scrambles it.
  initial begin
    raw_valid_o = 1'b0;
    raw_result_o = 16'h0000;
    forever begin
      @(posedge go_i);
      #2.3 raw_result_o = val_i;
      raw_valid_o = 1'b1;
      repeat (6) @(posedge clk_i);
      #1.1 raw_valid_o = 1'b0;
      #1 raw_result_o = ~val_i;
    end
  end
endmodule
`default_nettype wire

// ===== dv/osmc_chk.sv
`default_nettype none
module osmc_chk (
  // Clock and reset.
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  // Register port.
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_ack_o,
  input wire logic       sw_reset_busy_o,
  // Engine controls.
  input wire logic       light_enable_o,
  input wire logic       light_all_channels_o,
  input wire logic       optical_meas_enable_o,
  input wire logic [5:0] pulse_count_o,
  input wire logic [6:0] emitter_pulse_duration_o,
  input wire logic [2:0] prox_interval_o,
  input wire logic [4:0] prox_res_bits_o,
  // Raw result path.
  input wire logic       raw_valid_i,
  input wire logic       prox_result_valid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Accepted requests, and the write that starts a software reset.
  wire req = (reg_wr_i || reg_rd_i) && !sw_reset_busy_o;
  wire sw_wr = reg_wr_i && reg_addr_i == 8'h15 && reg_wdata_i[7] && req;
  wire acc_wr = reg_ack_o && reg_wr_i;
  property p_ack;
    req && !sw_wr |-> reg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_swrst;
    sw_wr |-> !reg_ack_o ##1 sw_reset_busy_o;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset wrong");
  property p_busy;
    sw_reset_busy_o |-> !reg_ack_o;
  endproperty
  a_busy: assert property (p_busy) else $error("ack while busy");
  property p_light;
    acc_wr && reg_addr_i == 8'h15 && reg_wdata_i[3:0] == 4'h1
      |=> light_enable_o;
  endproperty
  a_light: assert property (p_light) else $error("light not on");
  property p_chan;
    acc_wr && reg_addr_i == 8'h15 && reg_wdata_i[3:0] == 4'h3
      |=> light_all_channels_o;
  endproperty
  a_chan: assert property (p_chan) else $error("channels wrong");
  property p_prox_en;
    acc_wr && reg_addr_i == 8'h16 && reg_wdata_i[2:0] == 3'h1 &&
      !optical_meas_enable_o |-> ##2 optical_meas_enable_o;
  endproperty
  a_prox_en: assert property (p_prox_en) else $error("engine off");
  property p_cap;
    emitter_pulse_duration_o == 7'd71 && prox_interval_o == 3'd0
      |-> pulse_count_o <= 6'd8;
  endproperty
  a_cap: assert property (p_cap) else $error("pulse cap wrong");
  property p_res;
    emitter_pulse_duration_o == 7'd71 && pulse_count_o >= 6'd4
      |-> prox_res_bits_o == 5'd16;
  endproperty
  a_res: assert property (p_res) else $error("resolution wrong");
  property p_lat;
    $rose(raw_valid_i) |-> ##[2:3] prox_result_valid_o;
  endproperty
  a_lat: assert property (p_lat) else $error("result late");
  property p_pulse;
    prox_result_valid_o |=> !prox_result_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
endmodule
bind osmc_ctrl osmc_chk u_chk (.core_clk_i, .sys_rst_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o, .sw_reset_busy_o,
  .light_enable_o, .light_all_channels_o, .optical_meas_enable_o,
  .pulse_count_o, .emitter_pulse_duration_o, .prox_interval_o,
  .prox_res_bits_o, .raw_valid_i, .prox_result_valid_o);
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_ack_o, ack_v;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic [5:0] ev_v, pulse_count_o;
  logic [15:0] val, raw_result_i, prox_result_o;
  logic go, raw_valid_i, light_enable_o, light_all_channels_o;
  logic optical_meas_enable_o, led_sel_red_o, analog_offset_cancel_o;
  logic prox_result_valid_o, sw_reset_busy_o;
  logic [1:0] optical_meas_mode_o;
  logic [9:0] emitter_current_o;
  logic [6:0] emitter_pulse_duration_o;
  logic [2:0] prox_interval_o;
  logic [4:0] prox_res_bits_o;
  int fails = 0, checks = 0, i, j;
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'h01, 8'h1A, 8'h15, 0, 0};
  logic [7:0] mv [4] = '{8'h03, 8'h83, 8'h05, 8'h85};
  logic [7:0] cv [4] = '{8'h10, 8'h20, 8'h21, 8'h30};
  int dur [3] = '{26, 42, 71};
  // Design and the front-end model.
  osmc_ctrl #(.SWRST_CYCLES(20)) uut (.core_clk_i, .sys_rst_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
    .status0_rd_i(ev_v[5]), .status1_rd_i(ev_v[4]), .light_irq_i(ev_v[3]),
    .prox_irq_i(ev_v[2]), .light_done_i(ev_v[1]), .prox_done_i(ev_v[0]),
    .raw_valid_i, .raw_result_i, .light_enable_o, .light_all_channels_o,
    .optical_meas_enable_o, .optical_meas_mode_o, .led_sel_red_o,
    .emitter_current_o, .analog_offset_cancel_o, .pulse_count_o,
    .emitter_pulse_duration_o, .prox_interval_o, .prox_res_bits_o,
    .prox_result_o, .prox_result_valid_o, .sw_reset_busy_o);
  osmc_fe_model fe (.clk_i(core_clk_i), .go_i(go), .val_i(val),
    .raw_valid_o(raw_valid_i), .raw_result_o(raw_result_i));
  // Compares one value and counts the outcome.
  task automatic chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Byte write; the acknowledge is sampled before the taking edge.
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    #1 ack_v = reg_ack_o;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    #1 rd_v = reg_rdata_o;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  // One-cycle pulse on the status, interrupt and done inputs.
  task automatic ev(input logic [5:0] m);
    @(posedge core_clk_i);
    ev_v <= m;
    @(posedge core_clk_i);
    ev_v <= 6'h00;
  endtask
  task automatic setm(input logic [7:0] v);
    wr(8'h16, 8'h00);
    ev(6'h01);
    wr(8'h16, v);
    tk(2);
  endtask
  // Sends a raw sample and waits a bounded time for the cancelled result.
  task automatic raw(input logic [15:0] v, e);
    val <= v;
    go <= 1'b1;
    for (i = 0; i < 20 && prox_result_valid_o !== 1'b1; i++) tk(1);
    if (i == 20) begin
      fails++;
      stop_test();
    end
    chk("result", prox_result_o, e);
    go <= 1'b0;
    tk(8);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    {sys_rst_i, reg_wr_i, reg_rd_i, go} = 4'h8;
    {reg_addr_i, reg_wdata_i, ev_v, val} = 0;
    tk(5);
    sys_rst_i <= 1'b0;
    for (j = 0; j < 8; j++) begin
      rd(8'h15 + j);
      chk("reset value", rd_v, rv[j]);
    end
    chk("current", emitter_current_o, 16'h1FF);
    chk("pulses", pulse_count_o, 8);
    chk("width", emitter_pulse_duration_o, 42);
    chk("period", prox_interval_o, 5);
    chk("resolution", prox_res_bits_o, 15);
    chk("mode", optical_meas_mode_o, 0);
    chk("enables", {light_enable_o, optical_meas_enable_o}, 0);
    $display("test reset done");
    wr(8'h30, 8'h5A);
    rd(8'h30);
    chk("unmapped", rd_v, 0);
    wr(8'h17, 8'h34);
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h5A);
    tk(2);
    chk("current", emitter_current_o, 16'h234);
    chk("analog", analog_offset_cancel_o, 1);
    for (j = 0; j < 24; j++) begin
      wr(8'h1A, {2'b00, 2'(j / 8), 4'h5});
      wr(8'h19, {2'b00, 3'(j % 8), 3'b010});
      tk(2);
      chk("pulses", pulse_count_o, j % 8 > 4 ? 32 : 1 << j % 8);
      chk("width", emitter_pulse_duration_o, dur[j / 8]);
      i = 10 + 2 * (j / 8) + (j % 8 > 5 ? 5 : j % 8);
      chk("resolution", prox_res_bits_o, i > 16 ? 16 : i);
    end
    for (j = 0; j < 4; j++) begin
      wr(8'h1A, cv[j]);
      tk(2);
      chk("capped", pulse_count_o, j % 2 ? 8 : 16);
    end
    chk("reserved width", emitter_pulse_duration_o, 71);
    $display("test pulse settings done");
    for (j = 0; j < 4; j++) begin
      setm(mv[j]);
      chk("mode", optical_meas_mode_o, 1 + j / 2);
      chk("red", led_sel_red_o, j % 2);
      ev(6'h01);
      tk(2);
      chk("red next", led_sel_red_o, (j % 2) ^ (j / 2));
    end
    setm(8'h09);
    ev(6'h04);
    ev(6'h11);
    tk(2);
    rd(8'h16);
    chk("prox sleep", rd_v, 8'h08);
    setm(8'h01);
    ev(6'h04);
    ev(6'h11);
    rd(8'h16);
    chk("prox awake", rd_v, 8'h01);
    wr(8'h15, 8'h09);
    ev(6'h08);
    ev(6'h22);
    tk(1);
    chk("light sleep", light_enable_o, 0);
    ev(6'h20);
    tk(1);
    chk("light wake", light_enable_o, 1);
    wr(8'h15, 8'h01);
    ev(6'h08);
    ev(6'h22);
    tk(1);
    chk("light awake", light_enable_o, 1);
    chk("few channels", light_all_channels_o, 0);
    wr(8'h15, 8'h03);
    tk(1);
    chk("all channels", light_all_channels_o, 1);
    $display("test modes and sleep done");
    wr(8'h1B, 8'h10);
    wr(8'h1C, 8'h01);
    raw(16'h0150, 16'h0040);
    raw(16'h0100, 16'h0000);
    raw(16'hFFFF, 16'hFEEF);
    $display("test cancel done");
    wr(8'h15, 8'h80);
    tk(1);
    chk("reset ack", ack_v, 0);
    chk("busy", sw_reset_busy_o, 1);
    wr(8'h17, 8'h00);
    for (i = 0; i < 100 && sw_reset_busy_o !== 1'b0; i++) tk(1);
    if (i == 100) begin
      fails++;
      stop_test();
    end
    rd(8'h17);
    chk("after reset", rd_v, 8'hFF);
    rd(8'h1B);
    chk("after reset", rd_v, 8'h00);
    $display("test software reset done");
    stop_test();
  end
endmodule
`default_nettype wire
